// *** fdcr_pkg.sv ***
/*
 Shared constants and types for the floppy drive-control register bank.
 Assumes the bank sits on the 8-bit host I/O port at the primary base.
*/
package fdcr_pkg;

    // Host I/O addresses
    localparam logic [15:0] ADDR_PIN_STATUS_B = 16'h03f1;
    localparam logic [15:0] ADDR_DRIVE_OUTPUT = 16'h03f2;
    localparam logic [15:0] ADDR_TAPE_ASSIGN = 16'h03f3;

    // Reset values
    localparam logic [7:0] DRIVE_OUTPUT_RESET = 8'h00;
    localparam logic [1:0] TAPE_ASSIGN_RESET = 2'h0;

    // Drive output control fields
    localparam int DOC_DRV_LSB = 0;
    localparam int DOC_DRV_MSB = 1;
    localparam int DOC_SOFT_RESET_N = 2;
    localparam int DOC_DMA_IRQ_GATE = 3;
    localparam int DOC_MOTOR_BIT_0 = 4;
    localparam int DOC_MOTOR_BIT_1 = 5;

    // Pin status B fields, full-status mode
    localparam int PSB_MOTOR_0 = 0;
    localparam int PSB_MOTOR_1 = 1;
    localparam int PSB_WRITE_GATE_OUT = 2;
    localparam int PSB_RDATA = 3;
    localparam int PSB_WDATA = 4;
    localparam int PSB_DRV_LSB = 5;
    localparam int PSB_ONE_6 = 6;
    localparam int PSB_ONE_7 = 7;

    // Pin status B fields, latched-status mode
    localparam int PSB_SEL_C_N = 0;
    localparam int PSB_SEL_D_N = 1;
    localparam int PSB_SEL_A_N = 5;
    localparam int PSB_SEL_B_N = 6;
    localparam int PSB_DRV2_N = 7;

    // Tape drive assign fields
    localparam int TDA_BOOT_LSB = 2;
    localparam int TDA_TYPE_LSB = 4;

    // Shortest soft reset pulse
    localparam int SOFT_RESET_MIN_NS = 100;

    typedef enum logic [1:0] {
        FDCR_MODE_AT,
        FDCR_MODE_FULL,
        FDCR_MODE_LATCHED
    } fdcr_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } fdcr_io_req_t;

    typedef struct packed {
        fdcr_mode_t mode;
        logic swap;
        logic enhanced2;
        logic [1:0] bootDrive;
        logic [7:0] driveType;
    } fdcr_cfg_t;

    typedef struct packed {
        logic driveSelectAN;
        logic driveSelectBN;
        logic motorOn0N;
        logic motorOn1N;
    } fdcr_drive_pins_t;

endpackage

// *** fdcr_drive_ctl_regs.sv ***
/*
 Drive output control, tape drive assign and pin status B registers of a
 floppy controller, with the two-drive select and motor pin decode.
 Assumes: single-cycle read and write strobes from the host I/O decoder on
 core_clk; write gate and write data come from the controller's own logic
 on core_clk; read data comes from the drive pin and is synchronised here;
 configuration is static while in use.
*/
// How it works
// RULE1: full status bit 2 shows write gate
// RULE2: full status bit 3 toggles on read data
// RULE3: full status bit 4 toggles on write data
// RULE4: full status bit 5 mirrors drive number LSB
// RULE5: full status bits 6 and 7 read one
// RULE6: latched bits 0 and 1 read one
// RULE7: latched bit 2 catches write gate rise
// RULE8: latched bit 3 catches read data release
// RULE9: latched bit 4 catches write data release
// RULE10: latched bits 5,6 show low-active selects
// RULE11: drive output control writable, zero at reset
// RULE12: bits 1:0 give one binary drive number
// RULE13: bit 2 low holds soft reset
// RULE14: bit 3 gates DMA and interrupt
// RULE15: full status mode keeps DMA, interrupt enabled
// RULE16: bits 4,5 drive motors 0 and 1
// RULE17: normal decode of selects and motors
// RULE18: swapped decode exchanges both pin pairs
// RULE19: tape bits 1:0 assign tape drive
// RULE20: normal mode tape bits 7:2 read zero
// RULE21: enhanced mode shows boot drive, drive type
// RULE22: full status bits 0,1 show motors
// RULE23: plain mode status read leaves bus undriven
// RULE24: modes and types are static inputs
// RULE25: latched status bits clear on reset
`timescale 1ns/1ns

module fdcr_drive_ctl_regs #(
    parameter int CLK_NS = 100
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire fdcr_pkg::fdcr_io_req_t ioReq,
    output logic [7:0] ioRdData,
    output logic ioRdDataOe,
    output logic ioRdValid,
    input wire logic dirRead,
    input wire fdcr_pkg::fdcr_cfg_t cfg,
    input wire logic writeGateOut,
    input wire logic writeDataN,
    input wire logic readDataInN,
    output fdcr_pkg::fdcr_drive_pins_t drivePins,
    output logic dmaIrqGate,
    output logic softResetN,
    output logic [1:0] tapeAssign
);
    import fdcr_pkg::*;

    localparam int SR_CYC_RAW = (SOFT_RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SR_CYC = (SR_CYC_RAW < 1) ? 1 : SR_CYC_RAW;
    localparam int SR_W = $clog2(SR_CYC + 1);

    if (CLK_NS < 1) begin : g_bad_clk
        $error("CLK_NS must be positive");
    end

    logic [7:0] driveOutputControl_r;
    logic [1:0] tapeDriveAssign_r;
    logic rdSync1_r;
    logic rdSync2_r;
    logic rdPrev_r;
    logic wdPrev_r;
    logic wgPrev_r;
    logic rdToggle_r;
    logic wdToggle_r;
    logic wgLatch_r;
    logic rdLatch_r;
    logic wdLatch_r;
    logic [SR_W-1:0] srCount_r;
    logic [SR_W-1:0] srCount_nxt;
    logic softResetN_r;
    logic [7:0] rdData_r;
    logic rdOe_r;
    logic rdValid_r;
    fdcr_drive_pins_t pins_r;
    fdcr_drive_pins_t pins_nxt;
    logic rdRelease;
    logic wdRelease;
    logic wgRise;
    logic writeDoc;
    logic [7:0] pinStatusB;
    logic [7:0] tapeRead;
    logic [7:0] readValue;
    logic readDriven;

    // Drive-type pair of the drive numbered drv
    function automatic logic [1:0] typePair(input logic [7:0] types, input logic [1:0] drv);
        logic [1:0] pair;
        pair = 2'h0;
        case (drv)
            2'h0: pair = types[1:0];
            2'h1: pair = types[3:2];
            2'h2: pair = types[5:4];
            default: pair = types[7:6];
        endcase
        return pair;
    endfunction

    assign writeDoc = ioReq.wr && (ioReq.addr == ADDR_DRIVE_OUTPUT);

    // Drive output control register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            driveOutputControl_r <= DRIVE_OUTPUT_RESET; // RULE11
        end else if (writeDoc) begin
            driveOutputControl_r <= ioReq.wdata; // RULE11
        end
    end

    // Tape drive assign register, only the assign bits are stored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tapeDriveAssign_r <= TAPE_ASSIGN_RESET;
        end else if (ioReq.wr && (ioReq.addr == ADDR_TAPE_ASSIGN)) begin
            tapeDriveAssign_r <= ioReq.wdata[1:0]; // RULE19 RULE20
        end
    end

    assign tapeAssign = tapeDriveAssign_r; // RULE19

    // Soft reset stays low at least the minimum pulse, even if rewritten at once
    always_comb begin
        srCount_nxt = srCount_r;
        if (!driveOutputControl_r[DOC_SOFT_RESET_N]) begin
            srCount_nxt = SR_W'(SR_CYC);
        end else if (srCount_r != '0) begin
            srCount_nxt = srCount_r - SR_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            srCount_r <= '0;
            softResetN_r <= 1'b0;
        end else begin
            srCount_r <= srCount_nxt;
            softResetN_r <= driveOutputControl_r[DOC_SOFT_RESET_N]
                && (srCount_r == '0); // RULE13
        end
    end

    assign softResetN = softResetN_r;

    // Full-status mode ignores the gate bit
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dmaIrqGate <= 1'b0;
        end else if (cfg.mode == FDCR_MODE_FULL) begin // RULE24
            dmaIrqGate <= 1'b1; // RULE15
        end else begin
            dmaIrqGate <= driveOutputControl_r[DOC_DMA_IRQ_GATE]; // RULE14
        end
    end

    // Two-drive select and motor decode
    always_comb begin
        logic sel0;
        logic sel1;
        logic [1:0] drv;
        drv = driveOutputControl_r[DOC_DRV_MSB:DOC_DRV_LSB]; // RULE12
        sel0 = (drv == 2'h0) && driveOutputControl_r[DOC_MOTOR_BIT_0]; // RULE17
        sel1 = (drv == 2'h1) && driveOutputControl_r[DOC_MOTOR_BIT_1]; // RULE17
        if (cfg.swap) begin
            pins_nxt.driveSelectAN = !sel1; // RULE18
            pins_nxt.driveSelectBN = !sel0; // RULE18
            pins_nxt.motorOn0N = !driveOutputControl_r[DOC_MOTOR_BIT_1]; // RULE18
            pins_nxt.motorOn1N = !driveOutputControl_r[DOC_MOTOR_BIT_0]; // RULE18
        end else begin
            pins_nxt.driveSelectAN = !sel0; // RULE17
            pins_nxt.driveSelectBN = !sel1; // RULE17
            pins_nxt.motorOn0N = !driveOutputControl_r[DOC_MOTOR_BIT_0]; // RULE16
            pins_nxt.motorOn1N = !driveOutputControl_r[DOC_MOTOR_BIT_1]; // RULE16
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_r <= '1;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    assign drivePins = pins_r;

    // Read data pin synchroniser and previous-level stages
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdSync1_r <= 1'b1;
            rdSync2_r <= 1'b1;
            rdPrev_r <= 1'b1;
            wdPrev_r <= 1'b1;
            wgPrev_r <= 1'b0;
        end else begin
            rdSync1_r <= readDataInN;
            rdSync2_r <= rdSync1_r;
            rdPrev_r <= rdSync2_r;
            wdPrev_r <= writeDataN;
            wgPrev_r <= writeGateOut;
        end
    end

    // Data lines are active low, so release is a rising edge
    assign rdRelease = rdSync2_r && !rdPrev_r;
    assign wdRelease = writeDataN && !wdPrev_r;
    assign wgRise = writeGateOut && !wgPrev_r;

    // Toggle flags for full-status mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdToggle_r <= 1'b0;
            wdToggle_r <= 1'b0;
        end else begin
            rdToggle_r <= rdToggle_r ^ rdRelease; // RULE2
            wdToggle_r <= wdToggle_r ^ wdRelease; // RULE3
        end
    end

    // Latched flags: a new event wins over a clearing read
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wgLatch_r <= 1'b0; // RULE25
            rdLatch_r <= 1'b0; // RULE25
            wdLatch_r <= 1'b0; // RULE25
        end else begin
            wgLatch_r <= wgRise || (wgLatch_r && !dirRead); // RULE7
            rdLatch_r <= rdRelease || (rdLatch_r && !dirRead); // RULE8
            wdLatch_r <= wdRelease || (wdLatch_r && !dirRead); // RULE9
        end
    end

    // Pin status B contents per mode
    always_comb begin
        pinStatusB = '0;
        if (cfg.mode == FDCR_MODE_LATCHED) begin
            pinStatusB[PSB_SEL_C_N] = 1'b1; // RULE6
            pinStatusB[PSB_SEL_D_N] = 1'b1; // RULE6
            pinStatusB[PSB_WRITE_GATE_OUT] = wgLatch_r; // RULE7
            pinStatusB[PSB_RDATA] = rdLatch_r; // RULE8
            pinStatusB[PSB_WDATA] = wdLatch_r; // RULE9
            pinStatusB[PSB_SEL_A_N] = pins_r.driveSelectAN; // RULE10
            pinStatusB[PSB_SEL_B_N] = pins_r.driveSelectBN; // RULE10
            pinStatusB[PSB_DRV2_N] = 1'b1; // RULE10
        end else begin
            pinStatusB[PSB_MOTOR_0] = !pins_r.motorOn0N; // RULE22
            pinStatusB[PSB_MOTOR_1] = !pins_r.motorOn1N; // RULE22
            pinStatusB[PSB_WRITE_GATE_OUT] = writeGateOut; // RULE1
            pinStatusB[PSB_RDATA] = rdToggle_r; // RULE2
            pinStatusB[PSB_WDATA] = wdToggle_r; // RULE3
            pinStatusB[PSB_DRV_LSB] = driveOutputControl_r[DOC_DRV_LSB]; // RULE4
            pinStatusB[PSB_ONE_6] = 1'b1; // RULE5
            pinStatusB[PSB_ONE_7] = 1'b1; // RULE5
        end
    end

    // Tape drive assign read value
    always_comb begin
        tapeRead = {6'h00, tapeDriveAssign_r}; // RULE20
        if (cfg.enhanced2) begin
            tapeRead[TDA_BOOT_LSB +: 2] = cfg.bootDrive; // RULE21
            tapeRead[TDA_TYPE_LSB +: 2] = typePair(cfg.driveType,
                driveOutputControl_r[DOC_DRV_MSB:DOC_DRV_LSB]); // RULE21
        end
    end

    // Address decode for reads; plain mode leaves status B undriven
    always_comb begin
        readValue = '0;
        readDriven = 1'b0;
        case (ioReq.addr)
            ADDR_PIN_STATUS_B: begin
                readValue = pinStatusB;
                readDriven = (cfg.mode != FDCR_MODE_AT); // RULE23
            end
            ADDR_DRIVE_OUTPUT: begin
                readValue = driveOutputControl_r;
                readDriven = 1'b1;
            end
            ADDR_TAPE_ASSIGN: begin
                readValue = tapeRead;
                readDriven = 1'b1;
            end
            default: begin
                readValue = '0;
                readDriven = 1'b0;
            end
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_r <= '0;
            rdOe_r <= 1'b0;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= ioReq.rd;
            rdOe_r <= ioReq.rd && readDriven;
            rdData_r <= (ioReq.rd && readDriven) ? readValue : '0;
        end
    end

    assign ioRdData = rdData_r;
    assign ioRdDataOe = rdOe_r;
    assign ioRdValid = rdValid_r;

endmodule

// *** fdcr_drive_ctl_regs_checker.sv ***
/* Concurrent checks on the drive-control register bank ports.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ns
module fdcr_drive_ctl_regs_checker #(
    parameter int CLK_NS = 100
) (
    input logic core_clk,
    input logic rst_b,
    input fdcr_pkg::fdcr_io_req_t ioReq,
    input logic [7:0] ioRdData,
    input logic ioRdDataOe,
    input logic ioRdValid,
    input fdcr_pkg::fdcr_cfg_t cfg,
    input fdcr_pkg::fdcr_drive_pins_t drivePins,
    input logic dmaIrqGate,
    input logic softResetN
);
    import fdcr_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire rdSrb = ioReq.rd && ioReq.addr == ADDR_PIN_STATUS_B;
    wire wrDoc = ioReq.wr && ioReq.addr == ADDR_DRIVE_OUTPUT;
    property p_sel_one;
        !(!drivePins.driveSelectAN && !drivePins.driveSelectBN);
    endproperty
    a_sel_one: assert property (p_sel_one) else $error("two drives selected");
    property p_sel_mot;
        (!drivePins.driveSelectAN -> !drivePins.motorOn0N)
            && (!drivePins.driveSelectBN -> !drivePins.motorOn1N);
    endproperty
    a_sel_mot: assert property (p_sel_mot) else $error("select without motor");
    property p_full_dma;
        cfg.mode == FDCR_MODE_FULL ##1 cfg.mode == FDCR_MODE_FULL |-> dmaIrqGate;
    endproperty
    a_full_dma: assert property (p_full_dma) else $error("gate low in full mode");
    property p_wr_gate;
        wrDoc && cfg.mode != FDCR_MODE_FULL |-> ##2
            (cfg.mode == FDCR_MODE_FULL || dmaIrqGate == $past(ioReq.wdata[3], 2));
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("gate not from bit 3");
    property p_soft_lo;
        wrDoc && !ioReq.wdata[2] |-> ##2 !softResetN;
    endproperty
    a_soft_lo: assert property (p_soft_lo) else $error("soft reset not held");
    property p_soft_hold;
        $rose(softResetN) |-> !$past(softResetN, 2);
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft reset too short");
    property p_at_srb;
        rdSrb && cfg.mode == FDCR_MODE_AT |=> ioRdValid && !ioRdDataOe;
    endproperty
    a_at_srb: assert property (p_at_srb) else $error("status driven in AT mode");
    property p_full_hi;
        rdSrb && cfg.mode == FDCR_MODE_FULL |=> ioRdDataOe && ioRdData[7:6] == 2'h3;
    endproperty
    a_full_hi: assert property (p_full_hi) else $error("status top bits not one");
    property p_lat_sel;
        rdSrb && cfg.mode == FDCR_MODE_LATCHED |=> ioRdData[1:0] == 2'h3
            && ioRdData[5] == $past(drivePins.driveSelectAN)
            && ioRdData[6] == $past(drivePins.driveSelectBN);
    endproperty
    a_lat_sel: assert property (p_lat_sel) else $error("latched selects wrong");
    property p_tape_hi;
        ioReq.rd && ioReq.addr == ADDR_TAPE_ASSIGN && !cfg.enhanced2 |=>
            ioRdDataOe && ioRdData[7:2] == 6'h00;
    endproperty
    a_tape_hi: assert property (p_tape_hi) else $error("tape high bits set");
endmodule

bind fdcr_drive_ctl_regs fdcr_drive_ctl_regs_checker #(.CLK_NS(CLK_NS)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .ioReq(ioReq), .ioRdData(ioRdData),
    .ioRdDataOe(ioRdDataOe), .ioRdValid(ioRdValid), .cfg(cfg), .drivePins(drivePins),
    .dmaIrqGate(dmaIrqGate), .softResetN(softResetN));

// *** fdcr_drive_model.sv ***
/* Behavioural floppy drive producing read data pulses on request.
   Assumes the line idles high through a pull-up between pulses. */
`timescale 1ns/1ns
module fdcr_drive_model (
    input logic trig,
    output logic readDataInN
);
    initial readDataInN = 1'b1;
    // Pulse phase is unrelated to the controller clock
    always @(posedge trig) begin
        #37 readDataInN = 1'b0;
        #230 readDataInN = 1'b1;
    end
endmodule

// *** floppy_drive_control_regs_test.sv ***
/* Self-checking bench for the drive-control register bank.
   Assumes the drive model file and the bound checker are compiled first. */
`timescale 1ns/1ns
module floppy_drive_control_regs_test;
    import fdcr_pkg::*;
    logic core_clk, rst_b, ioRdDataOe, ioRdValid, dirRead, writeGateOut, writeDataN;
    logic readDataInN, rdPulse, dmaIrqGate, softResetN, latG, latR, latW, tgR, tgW;
    logic [7:0] ioRdData, doc, tape, d;
    logic [1:0] tapeAssign;
    fdcr_io_req_t ioReq;
    fdcr_cfg_t cfg;
    fdcr_drive_pins_t drivePins;
    int n_mismatch = 0;
    int compares = 0;

    fdcr_drive_ctl_regs DUT (.core_clk(core_clk), .rst_b(rst_b), .ioReq(ioReq),
        .ioRdData(ioRdData), .ioRdDataOe(ioRdDataOe), .ioRdValid(ioRdValid),
        .dirRead(dirRead), .cfg(cfg), .writeGateOut(writeGateOut), .writeDataN(writeDataN),
        .readDataInN(readDataInN), .drivePins(drivePins), .dmaIrqGate(dmaIrqGate),
        .softResetN(softResetN), .tapeAssign(tapeAssign));
    fdcr_drive_model drive (.trig(rdPulse), .readDataInN(readDataInN));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] v);
        @(posedge core_clk);
        ioReq.addr <= a;
        ioReq.wdata <= v;
        ioReq.wr <= 1'b1;
        @(posedge core_clk);
        ioReq.wr <= 1'b0;
    endtask

    // Returns the byte and checks the answer strobe one cycle after the request
    task automatic rd(logic [15:0] a, output logic [7:0] v, output logic oe);
        @(posedge core_clk);
        ioReq.addr <= a;
        ioReq.rd <= 1'b1;
        @(posedge core_clk);
        ioReq.rd <= 1'b0;
        #1;
        v = ioRdData;
        oe = ioRdDataOe;
        chk("valid", {7'h0, ioRdValid}, 8'h01);
    endtask

    function automatic logic [3:0] pins();
        logic s0, s1;
        s0 = doc[1:0] == 2'h0 && doc[4];
        s1 = doc[1:0] == 2'h1 && doc[5];
        return cfg.swap ? {!s1, !s0, !doc[5], !doc[4]} : {!s0, !s1, !doc[4], !doc[5]};
    endfunction

    function automatic logic [7:0] drive_pin_status_b();
        logic [3:0] p;
        p = pins();
        if (cfg.mode == FDCR_MODE_FULL)
            return {2'h3, doc[0], tgW, tgR, writeGateOut, !p[0], !p[1]};
        return {1'b1, p[2], p[3], latW, latR, latG, 2'h3};
    endfunction

    task automatic check_all();
        logic oe;
        tick(4);
        chk("pins", {4'h0, drivePins}, {4'h0, pins()});
        chk("gate", {7'h0, dmaIrqGate}, {7'h0, cfg.mode == FDCR_MODE_FULL || doc[3]});
        chk("sreset", {7'h0, softResetN}, {7'h0, doc[2]});
        chk("tapeAssign", {6'h0, tapeAssign}, {6'h0, tape[1:0]});
        rd(ADDR_DRIVE_OUTPUT, d, oe);
        chk("doc", d, doc);
        rd(ADDR_TAPE_ASSIGN, d, oe);
        chk("tape", d, cfg.enhanced2 ? {2'h0, cfg.driveType[2*doc[1:0] +: 2],
            cfg.bootDrive, tape[1:0]} : {6'h0, tape[1:0]});
        rd(ADDR_PIN_STATUS_B, d, oe);
        if (cfg.mode == FDCR_MODE_AT)
            chk("srb_oe", {7'h0, oe}, 8'h00);
        else
            chk("srb", d, drive_pin_status_b());
    endtask

    task automatic events();
        @(posedge core_clk) writeGateOut <= 1'b1;
        latG = 1'b1;
        @(posedge core_clk) writeDataN <= 1'b0;
        @(posedge core_clk) writeDataN <= 1'b1;
        rdPulse <= 1'b1;
        @(posedge core_clk) rdPulse <= 1'b0;
        {tgW, tgR, latW, latR} = {~tgW, ~tgR, 2'h3};
        tick(8);
    endtask

    task automatic clear_latch();
        @(posedge core_clk) dirRead <= 1'b1;
        @(posedge core_clk) dirRead <= 1'b0;
        {latG, latR, latW} = 3'h0;
    endtask

    initial begin
        logic oe;
        void'($urandom(6129));
        {ioReq, cfg, rst_b, dirRead, writeGateOut, rdPulse} = '0;
        writeDataN = 1'b1;
        {doc, tape, latG, latR, latW, tgR, tgW} = '0;
        tick(3);
        rst_b <= 1'b1;
        check_all();
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 8; i++) begin
                cfg.mode <= fdcr_mode_t'(m);
                cfg.swap <= i[0];
                cfg.enhanced2 <= i[1];
                cfg.bootDrive <= 2'($urandom);
                cfg.driveType <= 8'($urandom);
                doc = 8'($urandom);
                tape = 8'($urandom);
                wr(ADDR_DRIVE_OUTPUT, doc ^ 8'h04);
                wr(ADDR_DRIVE_OUTPUT, doc);
                wr(ADDR_TAPE_ASSIGN, tape);
                wr(ADDR_PIN_STATUS_B, 8'($urandom));
                check_all();
            end
        end
        rd(16'h03f0, d, oe);
        chk("unmapped", {oe, d[6:0]}, 8'h00);
        cfg.mode <= FDCR_MODE_FULL;
        events();
        check_all();
        @(posedge core_clk) writeGateOut <= 1'b0;
        cfg.mode <= FDCR_MODE_LATCHED;
        clear_latch();
        check_all();
        events();
        check_all();
        clear_latch();
        check_all();
        // Hardware reset in mid-run with every latch and toggle set
        @(posedge core_clk) writeGateOut <= 1'b0;
        events();
        writeGateOut <= 1'b0;
        rst_b <= 1'b0;
        tick(3);
        rst_b <= 1'b1;
        {doc, tape, latG, latR, latW, tgR, tgW} = '0;
        check_all();
        report_and_stop();
    end
endmodule
